// *** rtl/ircg_top.sv ***
// ircg_top: infrared carrier generator with a wishbone register slave
`timescale 1ns/1ps

// Functional notes
// - The carrier output is driven only while the enable bit is 1.
// - Frequency select 1 gives a 57 kHz carrier, 0 gives 38 kHz.
// - Polarity 0 emits while pin data is 1, polarity 1 while it is 0.
// - In crystal mode the crystal bit picks 3.58 MHz (1) or 455 kHz (0).
// - The crystal bit is ignored when the internal oscillator runs.
// - The carrier is made only from the high-frequency oscillator clock.
// - Internal oscillator at 4 MHz divides by 64 (57k) or 96 (38k).
// - A 3.58 MHz crystal divides by 64 (57k) or 96 (38k).
// - A 455 kHz crystal divides by 8 (57k) or 12 (38k).
module ircg_top #(
  parameter int unsigned AW = 8
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // oscillator and pin inputs
  input  wire logic          high_freq_osc_clock_i,
  input  wire logic          internal_high_rc_osc_i,
  input  wire logic          pin_data_i,
  // emitter drive
  output logic               carrier_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (AW < 6) begin : g_bad_aw
    $error("ircg_top: AW must be at least 6");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // half divide period for the chosen oscillator and carrier
  function automatic logic [ircg_pkg::DIV_W-1:0] half_of(
    input logic irc,
    input logic xtal_358,
    input logic f57
  );
    logic [ircg_pkg::DIV_W-1:0] div;
    div = ircg_pkg::DIV_HI_38;
    if (irc || xtal_358) begin
      div = f57 ? ircg_pkg::DIV_HI_57 : ircg_pkg::DIV_HI_38;
    end else begin
      div = f57 ? ircg_pkg::DIV_LO_57 : ircg_pkg::DIV_LO_38;
    end
    return div >> 1;
  endfunction

  function automatic logic hit(
    input logic [AW-1:0] adr,
    input logic [3:0]    idx
  );
    return adr == AW'({idx, ircg_pkg::ADDR_LSB'(0)});
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] osc_r;
  logic [2:0] osc_nxt;
  logic [1:0] irc_r;
  logic [1:0] irc_nxt;
  logic [1:0] pin_r;
  logic [1:0] pin_nxt;
  logic       tick;

  always_comb begin
    osc_nxt = {osc_r[1:0], high_freq_osc_clock_i};
    irc_nxt = {irc_r[0], internal_high_rc_osc_i};
    pin_nxt = {pin_r[0], pin_data_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_r <= 3'h0;
      irc_r <= 2'h0;
      pin_r <= 2'h0;
    end else begin
      osc_r <= osc_nxt;
      irc_r <= irc_nxt;
      pin_r <= pin_nxt;
    end
  end

  // rising edge of the oscillator, seen only past the second stage
  assign tick = osc_r[1] & ~osc_r[2];

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  ircg_pkg::ircg_wb_st_t wb_st_r;
  ircg_pkg::ircg_wb_st_t wb_st_nxt;
  ircg_pkg::ircg_ctrl_t  ctrl_r;
  ircg_pkg::ircg_ctrl_t  ctrl_nxt;
  logic [31:0]           dat_r;
  logic [31:0]           dat_nxt;
  logic                  req;
  logic                  carrier_r;
  logic                  wave;

  assign req = wb_cyc_i & wb_stb_i;

  // one wait state: ack in the cycle after the request is seen
  always_comb begin
    wb_st_nxt = wb_st_r;
    ctrl_nxt  = ctrl_r;
    dat_nxt   = dat_r;
    case (wb_st_r)
      ircg_pkg::WB_IDLE: begin
        if (req) begin
          wb_st_nxt = ircg_pkg::WB_ACK;
          dat_nxt   = 32'h0;
          // control is write-only, so it reads back as zero
          if (hit(wb_adr_i, ircg_pkg::STAT_IDX)) begin
            dat_nxt[ircg_pkg::ST_OUT]  = carrier_r;
            dat_nxt[ircg_pkg::ST_WAVE] = wave;
            dat_nxt[ircg_pkg::ST_IRC]  = irc_r[1];
            dat_nxt[ircg_pkg::ST_PIN]  = pin_r[1];
            dat_nxt[ircg_pkg::ST_CTRL +: 4] = ctrl_r;
          end
        end
      end
      ircg_pkg::WB_ACK: begin
        wb_st_nxt = ircg_pkg::WB_IDLE;
        // write lands on the edge where the master sees ack
        if (req && wb_we_i && wb_sel_i[0] &&
            hit(wb_adr_i, ircg_pkg::CTRL_IDX)) begin
          ctrl_nxt.en       = wb_dat_i[ircg_pkg::BIT_EN];
          ctrl_nxt.f57      = wb_dat_i[ircg_pkg::BIT_F57];
          ctrl_nxt.pol      = wb_dat_i[ircg_pkg::BIT_POL];
          ctrl_nxt.xtal_358 = wb_dat_i[ircg_pkg::BIT_XTAL];
        end
      end
      default: begin
        wb_st_nxt = ircg_pkg::WB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_st_r <= ircg_pkg::WB_IDLE;
      ctrl_r  <= ircg_pkg::CTRL_RST;
      dat_r   <= 32'h0;
    end else begin
      wb_st_r <= wb_st_nxt;
      ctrl_r  <= ctrl_nxt;
      dat_r   <= dat_nxt;
    end
  end

  assign wb_ack_o = (wb_st_r == ircg_pkg::WB_ACK);
  assign wb_dat_o = dat_r;

  // ----------------------------------------------------------------
  // carrier divider and gating
  // ----------------------------------------------------------------
  logic [ircg_pkg::DIV_W-1:0] half;
  logic [ircg_pkg::DIV_W-1:0] cnt;
  logic                       gate;
  logic                       carrier_nxt;

  assign half = half_of(irc_r[1], ctrl_r.xtal_358, ctrl_r.f57);

  ircg_div #(
    .W      (ircg_pkg::DIV_W)
  ) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (ctrl_r.en),
    .tick_i (tick),
    .half_i (half),
    .wave_o (wave),
    .cnt_o  (cnt)
  );

  // pin data is sampled, so the gate lags the pin by the synchroniser
  always_comb begin
    gate        = ctrl_r.pol ? ~pin_r[1] : pin_r[1];
    carrier_nxt = ctrl_r.en & gate & wave;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carrier_r <= 1'b0;
    end else begin
      carrier_r <= carrier_nxt;
    end
  end

  assign carrier_o = carrier_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_idle;
    !ctrl_r.en;
  endsequence

  sequence s_wrap;
    ctrl_r.en && tick && (cnt >= half - ircg_pkg::DIV_W'(1));
  endsequence

  property p_off;
    @(posedge clk_i) disable iff (rst_i)
    s_idle |=> !carrier_o;
  endproperty
  a_off: assert property (p_off)
    else $error("carrier driven while disabled");

  property p_freq;
    @(posedge clk_i) disable iff (rst_i)
    ctrl_r.f57 |-> (half == ircg_pkg::DIV_HI_57 >> 1) ||
                   (half == ircg_pkg::DIV_LO_57 >> 1);
  endproperty
  a_freq: assert property (p_freq)
    else $error("57k select gave a 38k ratio");

  property p_pol_block;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r.pol == pin_r[1]) |=> !carrier_o;
  endproperty
  a_pol_block: assert property (p_pol_block)
    else $error("carrier emitted at the wrong pin level");

  property p_pol_pass;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r.en && wave && ctrl_r.pol != pin_r[1]) |=> carrier_o;
  endproperty
  a_pol_pass: assert property (p_pol_pass)
    else $error("carrier missing at the active pin level");

  property p_x358;
    @(posedge clk_i) disable iff (rst_i)
    (!irc_r[1] && ctrl_r.xtal_358) |->
      half == (ctrl_r.f57 ? ircg_pkg::DIV_HI_57 >> 1
                          : ircg_pkg::DIV_HI_38 >> 1);
  endproperty
  a_x358: assert property (p_x358)
    else $error("wrong ratio for the 3.58 MHz crystal");

  property p_x455;
    @(posedge clk_i) disable iff (rst_i)
    (!irc_r[1] && !ctrl_r.xtal_358) |->
      half == (ctrl_r.f57 ? ircg_pkg::DIV_LO_57 >> 1
                          : ircg_pkg::DIV_LO_38 >> 1);
  endproperty
  a_x455: assert property (p_x455)
    else $error("wrong ratio for the 455 kHz crystal");

  property p_irc;
    @(posedge clk_i) disable iff (rst_i)
    irc_r[1] |->
      half == (ctrl_r.f57 ? ircg_pkg::DIV_HI_57 >> 1
                          : ircg_pkg::DIV_HI_38 >> 1);
  endproperty
  a_irc: assert property (p_irc)
    else $error("internal oscillator ratio depends on crystal bit");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_r.en && !tick) |=> $stable(wave) && $stable(cnt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("carrier moved without an oscillator edge");

  property p_toggle;
    @(posedge clk_i) disable iff (rst_i)
    s_wrap |=> (wave != $past(wave)) && (cnt == '0);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("carrier did not toggle at half period");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack not given for exactly one cycle");

  property p_wr_on;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && req && wb_we_i && wb_sel_i[0] &&
     wb_dat_i[ircg_pkg::BIT_EN] &&
     hit(wb_adr_i, ircg_pkg::CTRL_IDX)) |=> ctrl_r.en;
  endproperty
  a_wr_on: assert property (p_wr_on)
    else $error("enable write did not land on ack");

  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
    s_idle |=> (cnt == '0) && !wave;
  endproperty
  a_clear: assert property (p_clear)
    else $error("divider not cleared while disabled");

endmodule

// *** rtl/ircg_pkg.sv ***
// ircg_pkg: constants and types for the infrared carrier generator
package ircg_pkg;

  // ----------------------------------------------------------------
  // register map (word index, byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_IDX = 4'h6;
  localparam logic [3:0] STAT_IDX = 4'h7;
  localparam logic [1:0] ADDR_LSB = 2'h2;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_EN   = 0;
  localparam int unsigned BIT_F57  = 1;
  localparam int unsigned BIT_POL  = 2;
  localparam int unsigned BIT_XTAL = 7;

  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_OUT  = 0;
  localparam int unsigned ST_WAVE = 1;
  localparam int unsigned ST_IRC  = 2;
  localparam int unsigned ST_PIN  = 3;
  localparam int unsigned ST_CTRL = 8;

  // ----------------------------------------------------------------
  // divide ratios of the oscillator clock
  // ----------------------------------------------------------------
  localparam int unsigned DIV_W     = 7;
  localparam logic [6:0]  DIV_HI_57 = 7'h40;
  localparam logic [6:0]  DIV_HI_38 = 7'h60;
  localparam logic [6:0]  DIV_LO_57 = 7'h08;
  localparam logic [6:0]  DIV_LO_38 = 7'h0C;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic xtal_358;
    logic pol;
    logic f57;
    logic en;
  } ircg_ctrl_t;

  localparam ircg_ctrl_t CTRL_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

  typedef enum logic [0:0] {
    WB_IDLE = 1'b0,
    WB_ACK  = 1'b1
  } ircg_wb_st_t;

endpackage

// *** rtl/ircg_div.sv ***
// ircg_div: half-period counter that toggles the carrier square wave
`timescale 1ns/1ps
module ircg_div #(
  parameter int unsigned W = 7
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         run_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] half_i,
  // result
  output logic              wave_o,
  output logic [W-1:0]      cnt_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (W < 1) begin : g_bad_w
    $error("ircg_div: W must be at least 1");
  end

  logic         wave_r;
  logic         wave_nxt;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // >= so a shrinking ratio never leaves the count stranded above it
  always_comb begin
    cnt_nxt  = cnt_r;
    wave_nxt = wave_r;
    if (!run_i) begin
      cnt_nxt  = '0;
      wave_nxt = 1'b0;
    end else if (tick_i) begin
      if (cnt_r >= half_i - W'(1)) begin
        cnt_nxt  = '0;
        wave_nxt = ~wave_r;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= '0;
      wave_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      wave_r <= wave_nxt;
    end
  end

  assign wave_o = wave_r;
  assign cnt_o  = cnt_r;

endmodule

// *** bench/ircg_led.sv ***
// ircg_led: emitter model that measures each lit interval of the carrier
`timescale 1ns/1ps
module ircg_led (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // emitter drive
  input  wire logic        carrier_i,
  // measurement
  output logic             done_o,
  output logic [15:0]      width_o
);
  logic [15:0] cnt_r;

  // ------------------------------------------------------------
  // lit time in system clocks, reported as the led goes dark
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r   <= 16'h0000;
      done_o  <= 1'b0;
      width_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      if (carrier_i === 1'b1) begin
        cnt_r <= cnt_r + 16'h0001;
      end else if (cnt_r != 16'h0000) begin
        done_o  <= 1'b1;
        width_o <= cnt_r;
        cnt_r   <= 16'h0000;
      end
    end
  end
endmodule

// *** bench/testbench.sv ***
// testbench: self-checking bench of the infrared carrier generator
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int P = 6;
  logic        clk_i, rst_i, cyc, stb, we, osc, irc, pin;
  logic        wb_ack_o, carrier_o, done;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, wb_dat_o;
  logic [15:0] width;
  logic [15:0] wq[$];
  logic [63:0] rq[$];
  int          n_fail, num_checks, seed, oc, h;

  ircg_top ircg_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .high_freq_osc_clock_i(osc), .internal_high_rc_osc_i(irc),
    .pin_data_i(pin), .carrier_o(carrier_o));
  ircg_led ircg_led_inst (.clk_i(clk_i), .rst_i(rst_i),
    .carrier_i(carrier_o), .done_o(done), .width_o(width));

  // ------------------------------------------------------------
  // clock and oscillator (sampled input, P clocks a period)
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    oc  <= (oc == P - 1) ? 0 : oc + 1;
    osc <= (oc < P / 2);
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic fail(input string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_w(input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) fail("carrier lit time");
  endtask
  task automatic chk_d(input logic [63:0] e, input logic [31:0] g);
    num_checks++;
    if ((g & e[63:32]) !== e[31:0]) fail("read data");
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [63:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic wr_ctrl(input logic [7:0] c);
    logic [31:0] d;
    d = ($random(seed) & 32'hFFFFFF78) | {24'h0, c};
    wb(1'b1, 8'h18, d, 4'($random(seed)) | 4'h1);
  endtask

  // ------------------------------------------------------------
  // monitor: oldest note against each result
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!rst_i && wb_ack_o === 1'b1 && we === 1'b0 && rq.size() > 0)
      chk_d(rq.pop_front(), wb_dat_o);
    if (!rst_i && done === 1'b1) begin
      if (wq.size() > 0) chk_w(wq.pop_front(), width);
      else fail("carrier with no carrier expected");
    end
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    fail("timeout");
    end_sim;
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {cyc, stb, we, irc, pin} = '0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    seed = 18;
    n_fail = 0;
    num_checks = 0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // write-only control reads 0, unmapped reads 0
    rd(8'h18, 64'hFFFFFFFF_00000000);
    rd(8'h04, 64'hFFFFFFFF_00000000);
    // byte lane 0 off: write ignored
    wb(1'b1, 8'h18, 32'h0000_0001, 4'hE);
    rd(8'h1C, 64'h00000F00_00000000);
    // every oscillator mode, crystal kind and frequency
    for (int m = 0; m < 8; m++) begin
      irc <= m[2];
      pin <= 1'b1;
      h = (m[2] | m[1]) ? (m[0] ? 32 : 48) : (m[0] ? 4 : 6);
      wr_ctrl({m[1], 5'h00, m[0], 1'b1});
      rd(8'h1C, {32'h00000F0C, 20'h0, m[1], 1'b0, m[0], 1'b1,
                 4'h0, 1'b1, m[2], 2'b00});
      wq.push_back(16'(h * P));
      while (wq.size() != 0) @(posedge clk_i);
      wr_ctrl(8'h00);
    end
    // each polarity, pin at its emitting level
    irc <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      pin <= ~p[0];
      wr_ctrl({5'h00, p[0], 2'b01});
      wq.push_back(16'(48 * P));
      while (wq.size() != 0) @(posedge clk_i);
      wr_ctrl(8'h00);
    end
    // pin at the blocking level, then disabled: no carrier at all
    pin <= 1'b1;
    wr_ctrl(8'h05);
    repeat (700) @(posedge clk_i);
    wr_ctrl(8'h02);
    repeat (700) @(posedge clk_i);
    end_sim;
  end
endmodule
